// ===== rtl/dsc_pkg.sv
// Shared constants and types of the dual-slope conversion sequencer
package dsc_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Oscillator scaling
	localparam int CRYSTAL_DIVIDE = 58;
	localparam logic [5:0] DIV_LAST = 6'(CRYSTAL_DIVIDE - 1);

	////////////////////////////////////////////////////////////////////////////
	// Phase lengths in internal clock periods
	localparam int CYCLE_TICKS = 8192;
	localparam int INT_TICKS = 2048;
	localparam int ZI_MAX_TICKS = 1024;
	localparam int HOLD_LEAD_TICKS = 7;
	localparam logic [11:0] INT_LAST = 12'(INT_TICKS - 1);
	localparam logic [11:0] DE_LAST = 12'hFFF;
	localparam logic [11:0] ZI_LAST = 12'(ZI_MAX_TICKS - 1);
	localparam logic [11:0] AZ_LAST = 12'(CYCLE_TICKS - INT_TICKS - 4096 - 1);
	localparam logic [11:0] AZ_HOLD = 12'(CYCLE_TICKS - INT_TICKS - 4096 - HOLD_LEAD_TICKS);
	localparam logic [11:0] AZ_AFTER_ZI = 12'(ZI_MAX_TICKS);
	localparam logic [11:0] COUNT_RESET = 12'h000;

	////////////////////////////////////////////////////////////////////////////
	// Phases and carriers
	typedef enum logic [1:0] {
		PH_NULL = 2'b00,
		PH_INTEG = 2'b01,
		PH_DEINT = 2'b10,
		PH_CLEAR = 2'b11
	} dsc_phase_type;

	typedef struct packed {
		logic inputsToCommon;
		logic refCharge;
		logic nullLoop;
		logic inputsConnect;
		logic refPositive;
		logic refNegative;
		logic compToBuffer;
	} dsc_switch_type;

	typedef struct packed {
		logic signFlag;
		logic overRange;
		logic [11:0] magnitude;
	} dsc_result_type;

	localparam dsc_switch_type SWITCH_RESET = 7'h00;
	localparam dsc_result_type RESULT_RESET = 14'h0000;

endpackage : dsc_pkg

// ===== rtl/dsc_clk_div.sv
// Internal clock tick generator from the buffered oscillator
`timescale 1ns/1ps
`default_nettype none
module dsc_clk_div (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Oscillator configuration
	input wire logic oscillatorSelect,
	// Internal clock tick
	output logic tick_q
);
	import dsc_pkg::*;

	logic [5:0] divCount_q;
	logic [5:0] divCount_d;
	logic divWrap;

	assign divWrap = (divCount_q == DIV_LAST);
	assign divCount_d = (oscillatorSelect || divWrap) ? 6'h00 : 6'(divCount_q + 6'h01);

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			divCount_q <= 6'h00;
			tick_q <= 1'b0;
		end else begin
			divCount_q <= divCount_d;
			tick_q <= oscillatorSelect | divWrap;
		end
	end

endmodule : dsc_clk_div
`default_nettype wire

// ===== rtl/dsc_phase_counter.sv
// Twelve-bit phase counter stepping on internal clock ticks
`timescale 1ns/1ps
`default_nettype none
module dsc_phase_counter (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Control
	input wire logic tick,
	input wire logic stall,
	input wire logic load,
	input wire logic [11:0] loadValue,
	// Count
	output logic [11:0] count_q
);
	import dsc_pkg::*;

	logic [11:0] count_d;

	assign count_d = load ? loadValue : 12'(count_q + 12'h001);

	always_ff @(posedge sys_clk) begin
		if (reset)
			count_q <= COUNT_RESET;
		else if (tick && !stall)
			count_q <= count_d;
	end

endmodule : dsc_phase_counter
`default_nettype wire

// ===== rtl/dsc_sequencer.sv
// Dual-slope conversion sequencer top level
`timescale 1ns/1ps
`default_nettype none
module dsc_sequencer (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Configuration and control
	input wire logic oscillatorSelect,
	input wire logic runHold,
	input wire logic handshakeMode,
	input wire logic receiverReady,
	// Analog side
	input wire logic comparatorHigh,
	output dsc_pkg::dsc_switch_type switches_q,
	output dsc_pkg::dsc_phase_type phase_q,
	// Conversion results
	output logic activity_q,
	output dsc_pkg::dsc_result_type result_q,
	output logic transfer_q
);
	import dsc_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Internal clock and phase counter
	logic tick;
	logic [11:0] count;
	logic stall;
	logic load;
	logic [11:0] loadValue;

	dsc_clk_div u_clk_div (
		.sys_clk(sys_clk),
		.reset(reset),
		.oscillatorSelect(oscillatorSelect),
		.tick_q(tick)
	);

	dsc_phase_counter u_counter (
		.sys_clk(sys_clk),
		.reset(reset),
		.tick(tick),
		.stall(stall),
		.load(load),
		.loadValue(loadValue),
		.count_q(count)
	);

	////////////////////////////////////////////////////////////////////////////
	// Phase sequencing
	logic sign_q;
	logic sign_d;
	logic latched_q;
	logic latched_d;
	logic pending_q;
	logic pending_d;
	dsc_phase_type phase_d;
	dsc_result_type result_d;
	dsc_switch_type switches_d;
	logic crossing;
	logic atHold;
	logic intEnd;
	logic deEnd;
	logic ziEnd;
	logic azEnd;
	logic latchNow;
	logic overNow;
	logic toNull;
	logic fire;

	assign atHold = (phase_q == PH_NULL) && (count == AZ_HOLD) && !runHold;
	assign stall = atHold;
	assign azEnd = (phase_q == PH_NULL) && (count == AZ_LAST);
	assign intEnd = (phase_q == PH_INTEG) && (count == INT_LAST);
	assign deEnd = (phase_q == PH_DEINT) && (count == DE_LAST);
	assign ziEnd = (phase_q == PH_CLEAR) && (count == ZI_LAST);
	assign crossing = (phase_q == PH_DEINT) && !latched_q && (comparatorHigh != sign_q);
	assign latchNow = tick && crossing;
	assign overNow = tick && deEnd && !latched_q && !crossing;
	assign toNull = (phase_q == PH_DEINT) && ((latched_q || crossing) && (!runHold || deEnd));

	// Next phase; all moves happen on a tick
	always_comb begin
		phase_d = phase_q;
		load = 1'b0;
		loadValue = COUNT_RESET;
		if (azEnd) begin
			phase_d = PH_INTEG;
			load = 1'b1;
		end else if (intEnd) begin
			phase_d = PH_DEINT;
			load = 1'b1;
		end else if (toNull) begin
			phase_d = PH_NULL;
			load = 1'b1;
		end else if (deEnd) begin
			phase_d = PH_CLEAR;
			load = 1'b1;
		end else if (ziEnd) begin
			phase_d = PH_NULL;
			load = 1'b1;
			loadValue = AZ_AFTER_ZI;
		end
		if (!tick)
			phase_d = phase_q;
	end

	assign sign_d = (tick && intEnd) ? comparatorHigh : sign_q;
	assign latched_d = (phase_d == PH_INTEG) ? 1'b0 : (latched_q | latchNow | overNow);

	// Result latch: count, sign and over-range together
	always_comb begin
		result_d = result_q;
		if (latchNow) begin
			result_d.magnitude = count;
			result_d.signFlag = sign_q;
			result_d.overRange = 1'b0;
		end else if (overNow) begin
			result_d.magnitude = DE_LAST;
			result_d.signFlag = sign_q;
			result_d.overRange = 1'b1;
		end
	end

	// Switch network per phase
	function automatic dsc_switch_type switchesFor(input dsc_phase_type ph, input logic sgn);
		dsc_switch_type sw;
		sw = SWITCH_RESET;
		case (ph)
			PH_NULL: begin
				sw.inputsToCommon = 1'b1;
				sw.refCharge = 1'b1;
				sw.nullLoop = 1'b1;
			end
			PH_INTEG: begin
				sw.inputsConnect = 1'b1;
			end
			PH_DEINT: begin
				sw.refPositive = !sgn;
				sw.refNegative = sgn;
			end
			default: begin
				sw.refCharge = 1'b1;
				sw.compToBuffer = 1'b1;
			end
		endcase
		return sw;
	endfunction : switchesFor

	assign switches_d = switchesFor(phase_d, sign_d);

	// Result hand-over; a new result wins over a transfer in the same cycle
	assign fire = pending_q && (receiverReady || !handshakeMode);
	assign pending_d = latchNow | overNow | (pending_q & ~fire);

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			phase_q <= PH_NULL;
			sign_q <= 1'b0;
			latched_q <= 1'b0;
			pending_q <= 1'b0;
			result_q <= RESULT_RESET;
			switches_q <= SWITCH_RESET;
			activity_q <= 1'b0;
			transfer_q <= 1'b0;
		end else begin
			phase_q <= phase_d;
			sign_q <= sign_d;
			latched_q <= latched_d;
			pending_q <= pending_d;
			result_q <= result_d;
			switches_q <= switches_d;
			activity_q <= (phase_d == PH_INTEG) || ((phase_d == PH_DEINT) && !latched_d);
			transfer_q <= fire;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	logic [12:0] phaseTicks_q;
	logic [5:0] gap_q;
	logic gapValid_q;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			phaseTicks_q <= 13'h0000;
			gap_q <= 6'h00;
			gapValid_q <= 1'b0;
		end else begin
			phaseTicks_q <= (phase_d != phase_q) ? 13'h0000 : (tick ? 13'(phaseTicks_q + 13'h0001) : phaseTicks_q);
			gap_q <= tick ? 6'h00 : 6'(gap_q + 6'h01);
			gapValid_q <= oscillatorSelect ? 1'b0 : (tick ? 1'b1 : gapValid_q);
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	a_rc_tick: assert property (oscillatorSelect && $past(oscillatorSelect) && !$past(reset) |-> tick)
		else $error("tick missing with RC oscillator selected");
	a_xtal_ratio: assert property (tick && gapValid_q && !oscillatorSelect |-> gap_q == 6'h39)
		else $error("crystal tick spacing not 58");
	a_integ_length: assert property ($past(phase_q) == PH_INTEG && phase_q != PH_INTEG |-> $past(phaseTicks_q) == 13'h07FF)
		else $error("integration length wrong");
	a_clear_length: assert property ($past(phase_q) == PH_CLEAR && phase_q != PH_CLEAR |-> $past(phaseTicks_q) <= 13'h03FF)
		else $error("clearing too long");
	a_phase_order: assert property (phase_q != $past(phase_q)
		|-> (phase_q == PH_INTEG && $past(phase_q) == PH_NULL)
		|| (phase_q == PH_DEINT && $past(phase_q) == PH_INTEG)
		|| (phase_q == PH_NULL && $past(phase_q) != PH_INTEG)
		|| (phase_q == PH_CLEAR && $past(phase_q) == PH_DEINT))
		else $error("illegal phase order");
	a_clear_entry: assert property (phase_q == PH_CLEAR && $past(phase_q) == PH_DEINT |-> result_q.overRange && result_q.magnitude == DE_LAST)
		else $error("clearing without over range");
	a_sign_sample: assert property (phase_q == PH_DEINT && $past(phase_q) == PH_INTEG |-> sign_q == $past(comparatorHigh))
		else $error("sign not sampled at integration end");
	a_ref_polarity: assert property (phase_q == PH_DEINT |-> switches_q.refPositive != sign_q && switches_q.refNegative == sign_q)
		else $error("reference polarity wrong");
	a_null_switches: assert property (!$past(reset) && phase_q == PH_NULL |-> switches_q.nullLoop && switches_q.inputsToCommon && !switches_q.inputsConnect)
		else $error("nulling switches wrong");
	a_clear_switches: assert property (phase_q == PH_CLEAR |-> switches_q.compToBuffer && !switches_q.inputsConnect && switches_q.refCharge)
		else $error("clearing switches wrong");
	a_status_phase: assert property (phase_q == PH_NULL || phase_q == PH_CLEAR |-> !activity_q)
		else $error("activity high outside conversion");
	a_hold_stop: assert property (atHold && tick |=> phase_q == PH_NULL && count == AZ_HOLD)
		else $error("hold point not kept");
	a_resume: assert property (phase_q == PH_INTEG && $past(phase_q) == PH_NULL |-> activity_q)
		else $error("activity not raised at integration");
	a_count_latch: assert property (latchNow |=> result_q.magnitude == $past(count) && !result_q.overRange)
		else $error("count not latched at crossing");
	a_transfer_ready: assert property (transfer_q |-> $past(receiverReady) || !$past(handshakeMode))
		else $error("transfer without receiver ready");

	////////////////////////////////////////////////////////////////////////////
	// Phase entry, latch and hand-over checks
	a_integ_switches: assert property (phase_q == PH_INTEG
		|-> switches_q.inputsConnect && !switches_q.nullLoop && !switches_q.inputsToCommon)
		else $error("integration switches wrong");
	a_ref_idle: assert property (phase_q != PH_DEINT
		|-> !switches_q.refPositive && !switches_q.refNegative)
		else $error("reference connected outside de-integration");
	a_run_continuous: assert property (phase_q == PH_NULL && runHold && tick
		|=> $changed(count))
		else $error("nulling stalled while running");
	a_hold_lead: assert property (phase_q == PH_INTEG && $past(phase_q) == PH_NULL
		|-> $past(count) == AZ_LAST)
		else $error("integration not started from hold lead");
	a_activity_integ: assert property (phase_q == PH_INTEG
		|-> activity_q)
		else $error("activity low during integration");
	a_deint_start: assert property (phase_q == PH_DEINT && $past(phase_q) == PH_INTEG
		|-> count == COUNT_RESET)
		else $error("de-integration count not cleared");
	a_sign_kept: assert property (phase_q == PH_DEINT && $past(phase_q) == PH_DEINT
		|-> $stable(sign_q))
		else $error("sign changed during de-integration");
	a_activity_drop: assert property (latchNow
		|=> !activity_q)
		else $error("activity high after latch");
	a_sign_result: assert property (latchNow
		|=> result_q.signFlag == $past(sign_q))
		else $error("sign flag not latched");
	a_over_latch: assert property (overNow
		|=> result_q.overRange && result_q.magnitude == DE_LAST)
		else $error("over range not latched");
	a_over_clear: assert property (overNow
		|=> phase_q == PH_CLEAR)
		else $error("over range not followed by clearing");
	a_null_direct: assert property (phase_q == PH_NULL && $past(phase_q) == PH_DEINT
		|-> !result_q.overRange)
		else $error("nulling entered after over range");
	a_clear_resume: assert property (phase_q == PH_NULL && $past(phase_q) == PH_CLEAR
		|-> count == AZ_AFTER_ZI)
		else $error("nulling after clearing misaligned");
	a_pending_wait: assert property (pending_q && handshakeMode && !receiverReady
		|=> pending_q)
		else $error("result dropped before receiver ready");

	c_hold: cover property (atHold ##1 runHold);
	c_over: cover property (phase_q == PH_CLEAR);
	c_negative: cover property (latchNow && !sign_q);
	c_transfer: cover property (transfer_q && handshakeMode);
	c_crystal: cover property (phase_q == PH_INTEG && !oscillatorSelect);

endmodule : dsc_sequencer
`default_nettype wire

// ===== tb/dsc_analog_model.sv
// Behavioural integrator and comparator beside the sequencer
`timescale 1ns/1ps
`default_nettype none
module dsc_analog_model (
	// Clock
	input wire logic sys_clk,
	// Switches and input
	input wire dsc_pkg::dsc_switch_type switches,
	input wire logic signed [15:0] inputLevel,
	// Comparator
	output logic comparatorHigh
);
	import dsc_pkg::*;
	localparam int REF_STEP = 2048;
	int acc = 0;
	always_ff @(posedge sys_clk) begin
		if (switches.nullLoop || switches.compToBuffer)
			acc <= 0;
		else if (switches.refNegative)
			acc <= acc - REF_STEP;
		else if (switches.refPositive)
			acc <= acc + REF_STEP;
		else if (switches.inputsConnect)
			acc <= acc + int'(inputLevel);
	end
	assign comparatorHigh = acc > 0;
endmodule : dsc_analog_model
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench of the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
	import dsc_pkg::*;
	logic sys_clk, reset, oscillatorSelect, runHold, handshakeMode, receiverReady, comparatorHigh;
	logic signed [15:0] inputLevel;
	dsc_switch_type switches;
	dsc_phase_type phase;
	dsc_result_type result;
	logic activity, transfer;
	int errors = 0;
	int tests_run = 0;
	int cyc = 0;
	int prevStart = 0;

	dsc_sequencer dut_u (.sys_clk(sys_clk), .reset(reset), .oscillatorSelect(oscillatorSelect),
		.runHold(runHold), .handshakeMode(handshakeMode), .receiverReady(receiverReady),
		.comparatorHigh(comparatorHigh), .switches_q(switches), .phase_q(phase),
		.activity_q(activity), .result_q(result), .transfer_q(transfer));
	dsc_analog_model model_u (.sys_clk(sys_clk), .switches(switches), .inputLevel(inputLevel),
		.comparatorHigh(comparatorHigh));

	initial begin
		sys_clk = 0;
		forever #50 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) cyc <= cyc + 1;

	////////////////////////////////////////////////////////////////////////////
	task automatic results();
		$display("Counts: errors %0d compares %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : results

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic waitWhile(input dsc_phase_type p, output int n);
		n = 0;
		while (phase === p && n < 30000) begin
			@(negedge sys_clk);
			n++;
		end
		if (phase === p) begin
			errors++;
			$display("[ERR] %0t phase %0d stuck", $time, p);
		end
	endtask : waitWhile

	task automatic waitXfer(input int lim);
		int n;
		n = 0;
		while (transfer !== 1'b1 && n < lim) begin
			@(negedge sys_clk);
			n++;
		end
		check(16'(transfer), 16'h1);
	endtask : waitXfer

	////////////////////////////////////////////////////////////////////////////
	task automatic convert(input logic signed [15:0] v, input dsc_result_type exp, input logic over);
		int n;
		inputLevel = v;
		waitWhile(PH_NULL, n);
		if (prevStart != 0)
			check(16'(cyc - prevStart), 16'(CYCLE_TICKS));
		prevStart = cyc;
		check(16'(activity), 16'h1);
		check(16'({switches.inputsConnect, switches.nullLoop}), 16'h2);
		waitWhile(PH_INTEG, n);
		check(16'(n), 16'(INT_TICKS));
		check(16'(phase), 16'(PH_DEINT));
		check(16'({switches.refPositive, switches.refNegative}), 16'({~exp.signFlag, exp.signFlag}));
		waitXfer(4200);
		check(16'(result), 16'(exp));
		check(16'(activity), 16'h0);
		@(negedge sys_clk);
		check(16'(transfer), 16'h0);
		waitWhile(PH_DEINT, n);
		check(16'(phase), over ? 16'(PH_CLEAR) : 16'(PH_NULL));
		if (over) begin
			check(16'({switches.compToBuffer, switches.inputsConnect, switches.refCharge}), 16'h5);
			waitWhile(PH_CLEAR, n);
			check(16'(n <= ZI_MAX_TICKS), 16'h1);
			check(16'(phase), 16'(PH_NULL));
		end
		$display("convert %0d done", v);
	endtask : convert

	task automatic handshakeHold();
		int n;
		logic bad;
		bad = 0;
		handshakeMode = 1;
		receiverReady = 0;
		inputLevel = 16'sh0032;
		waitWhile(PH_NULL, n);
		runHold = 0;
		waitWhile(PH_INTEG, n);
		n = 0;
		while (activity === 1'b1 && n < 4200) begin
			@(negedge sys_clk);
			n++;
		end
		repeat (200) begin
			@(negedge sys_clk);
			bad |= (transfer !== 1'b0);
		end
		check(16'(bad), 16'h0);
		check(16'(phase), 16'(PH_NULL));
		receiverReady = 1;
		waitXfer(3);
		check(16'(result), 16'h2032);
		repeat (2100) @(negedge sys_clk);
		check(16'({phase, activity}), 16'h0);
		oscillatorSelect = 0;
		runHold = 1;
		waitWhile(PH_NULL, n);
		check(16'(n > 6 * CRYSTAL_DIVIDE && n <= 7 * CRYSTAL_DIVIDE), 16'h1);
		check(16'(activity), 16'h1);
		$display("handshake and hold done");
	endtask : handshakeHold

	////////////////////////////////////////////////////////////////////////////
	initial begin
		reset = 1;
		oscillatorSelect = 1;
		runHold = 1;
		handshakeMode = 0;
		receiverReady = 1;
		inputLevel = 0;
		repeat (3) @(negedge sys_clk);
		check(16'({phase, activity, transfer}), 16'h0);
		reset = 0;
		@(negedge sys_clk);
		check(16'({switches.inputsToCommon, switches.refCharge, switches.nullLoop}), 16'h7);
		$display("reset done");
		convert(16'sh0064, dsc_result_type'{1'b1, 1'b0, 12'h064}, 1'b0);
		convert(-16'sh012C, dsc_result_type'{1'b0, 1'b0, 12'h12D}, 1'b0);
		convert(16'sh1388, dsc_result_type'{1'b1, 1'b1, 12'hFFF}, 1'b1);
		convert(16'sh0007, dsc_result_type'{1'b1, 1'b0, 12'h007}, 1'b0);
		handshakeHold();
		results();
	end

	initial begin
		repeat (60000) @(posedge sys_clk);
		errors++;
		$display("[ERR] %0t watchdog expired", $time);
		results();
	end
endmodule : tb
`default_nettype wire
